/* File: hw/tdc_pkg.sv */
// Package for the time-of-day clock and scheduler: constants and types
package tdc_pkg;

	// Clock rate and timing
	localparam int CLK_MHZ       = 125;
	localparam int PWR_LOSS_US   = 30000;
	localparam int PWR_LOSS_CYC  = PWR_LOSS_US * CLK_MHZ;
	localparam int LAMP_MS       = 1000;
	localparam int LAMP_CYC      = LAMP_MS * 1000 * CLK_MHZ;
	localparam int MSG_MS        = 500;
	localparam int MSG_CYC       = MSG_MS * 1000 * CLK_MHZ;
	localparam int TIMEOUT_S     = 10;
	localparam int CNT_W         = 27;

	// Identity and fitted options; version value is arbitrary
	localparam logic [7:0] FW_VERSION = 8'h01;
	localparam logic       CTL_FITTED = 1'b1;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SYNC     = 8'h04;
	localparam logic [7:0] REG_SET      = 8'h08;
	localparam logic [7:0] REG_CODE     = 8'h0c;
	localparam logic [7:0] REG_SCHED    = 8'h10;
	localparam logic [7:0] SCHED_STRIDE = 8'h20;
	localparam logic [7:0] REG_STATUS   = 8'h70;
	localparam logic [7:0] REG_TIME     = 8'h74;

	// Schedule field offsets within one output block
	localparam logic [4:0] SF_MODE = 5'h00;
	localparam logic [4:0] SF_ON1  = 5'h04;
	localparam logic [4:0] SF_OFF1 = 5'h08;
	localparam logic [4:0] SF_ON2  = 5'h0c;
	localparam logic [4:0] SF_OFF2 = 5'h10;

	// Control register field positions and output count
	localparam int CTRL_FUNC_BIT = 0;
	localparam int CTRL_FMT_LSB  = 1;
	localparam int NUM_OUT       = 3;

	typedef enum logic {TDC_FUNC_ELAPSED = 1'b0, TDC_FUNC_CLOCK = 1'b1} tdc_func_t;
	typedef enum logic [1:0] {
		TDC_FMT_12     = 2'h0,
		TDC_FMT_12_SEC = 2'h1,
		TDC_FMT_24     = 2'h2,
		TDC_FMT_24_SEC = 2'h3
	} tdc_fmt_t;
	typedef enum logic [1:0] {
		TDC_SCH_OFF   = 2'h0,
		TDC_SCH_ONCE  = 2'h1,
		TDC_SCH_TWICE = 2'h2
	} tdc_sched_mode_t;
	typedef enum logic [6:0] {
		TDC_ST_LAMP = 7'h01,
		TDC_ST_LOAD = 7'h02,
		TDC_ST_RUN  = 7'h04,
		TDC_ST_CODE = 7'h08,
		TDC_ST_MENU = 7'h10,
		TDC_ST_DATA = 7'h20,
		TDC_ST_SAVE = 7'h40
	} tdc_state_t;
	typedef enum logic [2:0] {
		TDC_MSG_TIME = 3'h0,
		TDC_MSG_VER  = 3'h1,
		TDC_MSG_FUNC = 3'h2,
		TDC_MSG_ACC  = 3'h3,
		TDC_MSG_CODE = 3'h4,
		TDC_MSG_MENU = 3'h5,
		TDC_MSG_DATA = 3'h6,
		TDC_MSG_SAVE = 3'h7
	} tdc_msg_t;

	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} tdc_time_t;

	typedef struct packed {
		tdc_sched_mode_t mode;
		tdc_time_t       on1;
		tdc_time_t       off1;
		tdc_time_t       on2;
		tdc_time_t       off2;
	} tdc_sched_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tdc_bus_req_t;

	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic       show_sec;
		logic       am_mark;
		logic       pm_mark;
		logic       flash;
		logic       all_seg;
		logic       reset_ann;
		logic       status_ann;
		tdc_msg_t   msg;
		logic [7:0] info;
	} tdc_disp_t;

	localparam tdc_time_t  TIME_NOON = '{hh: 5'h0c, mm: 6'h00, ss: 6'h00};
	localparam tdc_time_t  TIME_ZERO = '{hh: 5'h00, mm: 6'h00, ss: 6'h00};
	localparam logic [15:0] CODE_DEF = 16'h0000;

endpackage

/* File: hw/tdc_clock.sv */
// Time-of-day clock with menu access control and three scheduled outputs
`timescale 1ns/1ns

// How it works
// [R01] Lamp test, then load stored configuration
// [R02] Flash and halt until set or synced
// [R03] Supply loss over 30ms returns unset
// [R04] Contacts shorted hold sync time, resume after
// [R05] Reset annunciator while contacts shorted
// [R06] Status annunciator mirrors status output on
// [R07] Four display formats, 12/24, seconds optional
// [R08] Status output off, once or twice daily
// [R09] Control output 1 scheduled like status
// [R10] Control output 2 identical, own settings
// [R11] P+E opens menu, code first if nonzero
// [R12] Code digits: up/down, P next, E accept
// [R13] Wrong code or ten idle seconds exit
// [R14] Changed settings show data then save
// [R15] Set time applies on return to display
// [R16] Factory defaults: code 0000, clock, noon
// [R17] Function select gates clock behaviour
// [R18] Single press cycles version, function, accessories
// [R19] 12-hour format marks morning and afternoon
// [R20] Once-daily mode offers only first times
// [R21] Outputs switch on exact time match
// [R22] Counter rolls 23:59:59 to 00:00:00
module tdc_clock #(
	parameter int PWR_LOSS_CYC_P = tdc_pkg::PWR_LOSS_CYC,
	parameter int LAMP_CYC_P     = tdc_pkg::LAMP_CYC,
	parameter int MSG_CYC_P      = tdc_pkg::MSG_CYC
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Register port
	input  wire tdc_pkg::tdc_bus_req_t bus_req,
	output      logic [31:0]           bus_rdata,
	// Pins from outside
	input  wire logic                  tick_1s_pin,
	input  wire logic                  sync_short_pin,
	input  wire logic                  btn_up_pin,
	input  wire logic                  btn_down_pin,
	input  wire logic                  btn_p_pin,
	input  wire logic                  btn_e_pin,
	input  wire logic                  supply_ok_pin,
	input  wire logic                  nvm_ready_pin,
	// Display
	output      tdc_pkg::tdc_disp_t    disp,
	// Outputs
	output      logic                  status_oc_out,
	output      logic                  status_oc_oe_n,
	output      logic                  control_output_one,
	output      logic                  control_output_two,
	output      logic                  nvm_load,
	output      logic                  nvm_store
);
	import tdc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic [7:0] pin_s1_r;
	logic [7:0] pin_s2_r;
	logic [7:0] pin_s3_r;
	logic [7:0] pin_rise;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 8'h00;
			pin_s2_r <= 8'h00;
			pin_s3_r <= 8'h00;
		end else begin
			pin_s1_r <= {nvm_ready_pin, supply_ok_pin, btn_e_pin, btn_p_pin,
				btn_down_pin, btn_up_pin, sync_short_pin, tick_1s_pin};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	assign pin_rise = pin_s2_r & ~pin_s3_r;

	logic tick_ev;
	logic sync_s;
	logic supply_s;
	logic nvm_ready_s;
	logic up_ev;
	logic down_ev;
	logic p_ev;
	logic e_ev;
	logic pe_ev;
	logic any_btn;

	assign tick_ev     = pin_rise[0];
	assign sync_s      = pin_s2_r[1];
	assign supply_s    = pin_s2_r[6];
	assign nvm_ready_s = pin_s2_r[7];
	assign pe_ev       = pin_s2_r[4] && pin_s2_r[5] && (pin_rise[4] || pin_rise[5]);
	assign up_ev       = pin_rise[2];
	assign down_ev     = pin_rise[3];
	assign p_ev        = pin_rise[4] && !pin_s2_r[5];
	assign e_ev        = pin_rise[5] && !pin_s2_r[4];
	assign any_btn     = |pin_rise[5:2];

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	tdc_state_t state_r;
	tdc_func_t  func_r;
	tdc_fmt_t   fmt_r;
	tdc_time_t  sync_time_r;
	tdc_time_t  set_time_r;
	logic       set_pend_r;
	logic [15:0] code_r;
	logic       changed_r;
	tdc_sched_t sched_r [NUM_OUT];
	logic       bus_wr_ok;
	logic       clock_on;

	assign bus_wr_ok = bus_req.wr && (state_r == TDC_ST_MENU);
	assign clock_on  = (func_r == TDC_FUNC_CLOCK); // see [R17]

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			func_r      <= TDC_FUNC_CLOCK; // see [R16]
			fmt_r       <= TDC_FMT_12;
			sync_time_r <= TIME_NOON;
			set_time_r  <= TIME_NOON;
			code_r      <= CODE_DEF;
			changed_r   <= 1'b0;
			set_pend_r  <= 1'b0;
		end else begin
			if (bus_wr_ok) begin
				changed_r <= 1'b1;
				case (bus_req.addr)
					REG_CTRL: begin
						func_r <= tdc_func_t'(bus_req.wdata[CTRL_FUNC_BIT]); // see [R17]
						fmt_r  <= tdc_fmt_t'(bus_req.wdata[CTRL_FMT_LSB +: 2]); // see [R07]
					end
					REG_SYNC: sync_time_r <= tdc_time_t'(bus_req.wdata[16:0]);
					REG_SET: begin
						set_time_r <= tdc_time_t'(bus_req.wdata[16:0]);
						set_pend_r <= 1'b1;
					end
					REG_CODE: code_r <= bus_req.wdata[15:0];
					default: ;
				endcase
			end else if (state_r == TDC_ST_RUN) begin
				changed_r  <= 1'b0;
				set_pend_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Schedule registers, one block per output
	genvar gi;
	logic [NUM_OUT-1:0] out_on_r;
	tdc_time_t          time_r;
	tdc_time_t          time_nxt;
	logic               run_tick;

	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			localparam logic [7:0] BASE = REG_SCHED + SCHED_STRIDE * 8'(gi);
			logic       hit;
			logic [4:0] fld;
			logic       twice;
			logic       on_hit;
			logic       off_hit;

			assign hit   = bus_wr_ok && (bus_req.addr >= BASE)
				&& (bus_req.addr <= BASE + 8'(SF_OFF2));
			assign fld   = 5'(bus_req.addr - BASE);
			assign twice = (sched_r[gi].mode == TDC_SCH_TWICE);

			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sched_r[gi] <= '{mode: TDC_SCH_OFF, on1: TIME_NOON, off1: TIME_NOON,
						on2: TIME_NOON, off2: TIME_NOON}; // see [R16]
				end else if (hit) begin
					case (fld)
						SF_MODE: sched_r[gi].mode <= tdc_sched_mode_t'(bus_req.wdata[1:0]);
						SF_ON1:  sched_r[gi].on1  <= tdc_time_t'(bus_req.wdata[16:0]);
						SF_OFF1: sched_r[gi].off1 <= tdc_time_t'(bus_req.wdata[16:0]);
						SF_ON2: begin
							if (twice) begin // see [R20]
								sched_r[gi].on2 <= tdc_time_t'(bus_req.wdata[16:0]);
							end
						end
						SF_OFF2: begin
							if (twice) begin // see [R20]
								sched_r[gi].off2 <= tdc_time_t'(bus_req.wdata[16:0]);
							end
						end
						default: ;
					endcase
				end
			end

			assign on_hit  = (time_nxt == sched_r[gi].on1) || (twice && time_nxt == sched_r[gi].on2);
			assign off_hit = (time_nxt == sched_r[gi].off1) || (twice && time_nxt == sched_r[gi].off2);

			// Switching on exact match, once per second
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					out_on_r[gi] <= 1'b0;
				end else if (!clock_on || sched_r[gi].mode == TDC_SCH_OFF) begin
					out_on_r[gi] <= 1'b0; // see [R08] see [R09] see [R10]
				end else if (run_tick) begin
					if (on_hit) begin
						out_on_r[gi] <= 1'b1; // see [R21]
					end else if (off_hit) begin
						out_on_r[gi] <= 1'b0; // see [R21]
					end
				end
			end
		end
	endgenerate

	assign status_oc_out      = 1'b0;
	assign status_oc_oe_n     = !out_on_r[0];
	assign control_output_one = out_on_r[1] && CTL_FITTED; // see [R09]
	assign control_output_two = out_on_r[2] && CTL_FITTED; // see [R10]

	////////////////////////////////////////////////////////////////////////
	// Timekeeping, sync contacts and supply monitor
	logic             unset_r;
	logic             sync_hold;
	logic             sync_was_r;
	logic [CNT_W-1:0] pwr_cnt_r;
	logic             pwr_lost;
	logic             menu_leave;

	function automatic tdc_time_t time_inc(input tdc_time_t t);
		tdc_time_t r;
		r = t;
		if (t.ss == 6'h3b) begin
			r.ss = 6'h00;
			if (t.mm == 6'h3b) begin
				r.mm = 6'h00;
				r.hh = (t.hh == 5'h17) ? 5'h00 : t.hh + 5'h01; // see [R22]
			end else begin
				r.mm = t.mm + 6'h01;
			end
		end else begin
			r.ss = t.ss + 6'h01;
		end
		return r;
	endfunction

	assign sync_hold = clock_on && sync_s;
	assign pwr_lost  = (pwr_cnt_r == CNT_W'(PWR_LOSS_CYC_P));
	assign run_tick  = tick_ev && clock_on && !unset_r && !sync_hold;
	assign time_nxt  = time_inc(time_r);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_cnt_r <= '0;
		end else if (supply_s) begin
			pwr_cnt_r <= '0;
		end else if (!pwr_lost) begin
			pwr_cnt_r <= pwr_cnt_r + CNT_W'(1); // see [R03]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			time_r     <= TIME_ZERO;
			unset_r    <= 1'b1;
			sync_was_r <= 1'b0;
		end else begin
			sync_was_r <= sync_hold;
			if (pwr_lost || state_r == TDC_ST_LAMP || state_r == TDC_ST_LOAD) begin
				time_r  <= TIME_ZERO; // see [R03]
				unset_r <= 1'b1; // see [R02]
			end else if (sync_hold) begin
				time_r <= sync_time_r; // see [R04]
			end else if (sync_was_r) begin
				unset_r <= 1'b0; // see [R02] see [R04]
			end else if (set_pend_r && state_r != TDC_ST_RUN
					&& (state_r == TDC_ST_SAVE || state_r == TDC_ST_MENU) && menu_leave) begin
				time_r  <= set_time_r; // see [R15]
				unset_r <= 1'b0; // see [R02]
			end else if (run_tick) begin
				time_r <= time_nxt; // see [R22]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operating state: power-up, code entry, menu, save
	logic [CNT_W-1:0] cnt_r;
	logic [3:0]       idle_r;
	logic [15:0]      entry_r;
	logic [1:0]       digit_r;
	logic             prompt_r;
	logic [1:0]       info_r;
	logic             idle_out;
	logic [3:0]       cur_dig;

	assign idle_out   = (idle_r == 4'(TIMEOUT_S));
	assign menu_leave = (state_r == TDC_ST_SAVE && cnt_r == CNT_W'(MSG_CYC_P))
		|| (state_r == TDC_ST_MENU && !changed_r && (e_ev || idle_out));
	assign cur_dig    = entry_r[digit_r*4 +: 4];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r <= 4'h0;
		end else if (state_r != TDC_ST_CODE && state_r != TDC_ST_MENU) begin
			idle_r <= 4'h0;
		end else if (any_btn) begin
			idle_r <= 4'h0;
		end else if (tick_ev && !idle_out) begin
			idle_r <= idle_r + 4'h1; // see [R13]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r  <= TDC_ST_LAMP;
			cnt_r    <= '0;
			entry_r  <= 16'h0000;
			digit_r  <= 2'h0;
			prompt_r <= 1'b0;
			info_r   <= 2'h0;
		end else begin
			cnt_r <= cnt_r + CNT_W'(1);
			case (state_r)
				TDC_ST_LAMP: begin
					if (cnt_r == CNT_W'(LAMP_CYC_P)) begin
						state_r <= TDC_ST_LOAD; // see [R01]
					end
				end
				TDC_ST_LOAD: begin
					if (nvm_ready_s) begin
						state_r <= TDC_ST_RUN; // see [R01]
					end
				end
				TDC_ST_RUN: begin
					if (pe_ev && clock_on) begin
						info_r   <= 2'h0;
						entry_r  <= 16'h0000;
						digit_r  <= 2'h0;
						prompt_r <= 1'b1;
						state_r  <= (code_r == CODE_DEF) ? TDC_ST_MENU : TDC_ST_CODE; // see [R11]
					end else if (up_ev) begin
						info_r <= info_r + 2'h1; // see [R18]
					end
				end
				TDC_ST_CODE: begin
					if (idle_out) begin
						state_r <= TDC_ST_RUN; // see [R13]
					end else if (prompt_r) begin
						prompt_r <= !p_ev;
					end else if (e_ev) begin
						state_r <= (entry_r == code_r) ? TDC_ST_MENU : TDC_ST_RUN; // see [R12] see [R13]
					end else if (p_ev) begin
						digit_r <= digit_r + 2'h1; // see [R12]
					end else if (up_ev) begin
						entry_r[digit_r*4 +: 4] <= (cur_dig == 4'h9) ? 4'h0 : cur_dig + 4'h1;
					end else if (down_ev) begin
						entry_r[digit_r*4 +: 4] <= (cur_dig == 4'h0) ? 4'h9 : cur_dig - 4'h1;
					end
				end
				TDC_ST_MENU: begin
					cnt_r <= '0;
					if (e_ev || idle_out) begin
						state_r <= changed_r ? TDC_ST_DATA : TDC_ST_RUN; // see [R14]
					end
				end
				TDC_ST_DATA: begin
					if (cnt_r == CNT_W'(MSG_CYC_P)) begin
						cnt_r   <= '0;
						state_r <= TDC_ST_SAVE; // see [R14]
					end
				end
				TDC_ST_SAVE: begin
					if (cnt_r == CNT_W'(MSG_CYC_P)) begin
						state_r <= TDC_ST_RUN; // see [R14]
					end
				end
				default: state_r <= TDC_ST_RUN;
			endcase
			if (state_r != TDC_ST_LAMP && state_r != TDC_ST_DATA && state_r != TDC_ST_SAVE
					&& state_r != TDC_ST_MENU) begin
				cnt_r <= (state_r == TDC_ST_LAMP) ? cnt_r + CNT_W'(1) : '0;
			end
		end
	end

	assign nvm_load  = (state_r == TDC_ST_LOAD);
	assign nvm_store = (state_r == TDC_ST_SAVE);

	////////////////////////////////////////////////////////////////////////
	// Display driver
	logic       is12;
	logic [4:0] hr12;

	assign is12 = (fmt_r == TDC_FMT_12) || (fmt_r == TDC_FMT_12_SEC);
	assign hr12 = (time_r.hh == 5'h00) ? 5'h0c :
		(time_r.hh > 5'h0c) ? time_r.hh - 5'h0c : time_r.hh;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			disp <= '0;
		end else begin
			disp.hours      <= is12 ? hr12 : time_r.hh; // see [R07]
			disp.minutes    <= time_r.mm;
			disp.seconds    <= time_r.ss;
			disp.show_sec   <= fmt_r[0] || state_r == TDC_ST_MENU;
			disp.am_mark    <= is12 && time_r.hh < 5'h0c; // see [R19]
			disp.pm_mark    <= is12 && time_r.hh >= 5'h0c; // see [R19]
			disp.flash      <= unset_r; // see [R02]
			disp.all_seg    <= (state_r == TDC_ST_LAMP); // see [R01]
			disp.reset_ann  <= sync_hold; // see [R05]
			disp.status_ann <= out_on_r[0]; // see [R06]
			disp.info       <= FW_VERSION;
			case (state_r)
				TDC_ST_CODE: disp.msg <= prompt_r ? TDC_MSG_CODE : TDC_MSG_MENU;
				TDC_ST_MENU: disp.msg <= TDC_MSG_MENU;
				TDC_ST_DATA: disp.msg <= TDC_MSG_DATA;
				TDC_ST_SAVE: disp.msg <= TDC_MSG_SAVE;
				TDC_ST_RUN:  disp.msg <= tdc_msg_t'({1'b0, info_r}); // see [R18]
				default:     disp.msg <= TDC_MSG_TIME;
			endcase
			if (state_r == TDC_ST_CODE) begin
				disp.info <= {4'h0, cur_dig};
			end else if (info_r == 2'h2) begin
				disp.info <= {7'h00, func_r};
			end else if (info_r == 2'h3) begin
				disp.info <= {7'h00, CTL_FITTED};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read port
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (bus_req.addr)
			REG_CTRL:   rd_nxt = {29'h0, fmt_r, func_r};
			REG_SYNC:   rd_nxt = {15'h0, sync_time_r};
			REG_SET:    rd_nxt = {15'h0, set_time_r};
			REG_CODE:   rd_nxt = {16'h0, code_r};
			REG_STATUS: rd_nxt = {21'h0, state_r, out_on_r, unset_r};
			REG_TIME:   rd_nxt = {15'h0, time_r};
			default:    rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			bus_rdata <= rd_nxt;
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_lamp;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_r == TDC_ST_LAMP) |=> disp.all_seg;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp test not shown"); // see [R01]

	property p_unset_halt;
		@(posedge sys_clk) disable iff (!rst_n)
		(unset_r && !sync_hold && !sync_was_r && !set_pend_r) |=> $stable(time_r);
	endproperty
	a_unset_halt: assert property (p_unset_halt) else $error("time ran while unset"); // see [R02]

	property p_pwr;
		@(posedge sys_clk) disable iff (!rst_n)
		pwr_lost |=> unset_r && time_r == TIME_ZERO;
	endproperty
	a_pwr: assert property (p_pwr) else $error("supply loss not handled"); // see [R03]

	property p_sync;
		@(posedge sys_clk) disable iff (!rst_n)
		(sync_hold && !pwr_lost && state_r == TDC_ST_RUN) |=> time_r == $past(sync_time_r);
	endproperty
	a_sync: assert property (p_sync) else $error("sync time not held"); // see [R04]

	property p_reset_ann;
		@(posedge sys_clk) disable iff (!rst_n)
		sync_hold |=> disp.reset_ann;
	endproperty
	a_reset_ann: assert property (p_reset_ann) else $error("reset annunciator off"); // see [R05]

	property p_status_ann;
		@(posedge sys_clk) disable iff (!rst_n)
		##1 disp.status_ann == !$past(status_oc_oe_n);
	endproperty
	a_status_ann: assert property (p_status_ann) else $error("status annunciator wrong"); // see [R06]

	property p_sched_off;
		@(posedge sys_clk) disable iff (!rst_n)
		(sched_r[1].mode == TDC_SCH_OFF) |=> !control_output_one;
	endproperty
	a_sched_off: assert property (p_sched_off) else $error("disabled output on"); // see [R09]

	property p_rollover;
		@(posedge sys_clk) disable iff (!rst_n)
		(run_tick && time_r == '{hh: 5'h17, mm: 6'h3b, ss: 6'h3b} && !pwr_lost
			&& !sync_was_r && !set_pend_r) |=> time_r == TIME_ZERO;
	endproperty
	a_rollover: assert property (p_rollover) else $error("midnight rollover wrong"); // see [R22]

	property p_bad_code;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_r == TDC_ST_CODE && !prompt_r && !idle_out && e_ev && entry_r != code_r)
			|=> state_r == TDC_ST_RUN;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("wrong code accepted"); // see [R13]

	c_menu: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == TDC_ST_CODE ##1 state_r == TDC_ST_MENU);
	c_save: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == TDC_ST_SAVE ##1 state_r == TDC_ST_RUN);
	c_sync: cover property (@(posedge sys_clk) disable iff (!rst_n)
		sync_was_r && !sync_hold);

endmodule // tdc_clock

/* File: sim/tdc_panel_model.sv */
// Front panel buttons, sync contact and one-second time base model
`timescale 1ns/1ns
module tdc_panel_model (
	// Clock
	input  wire logic sys_clk,
	// Panel and contact pins
	output logic      btn_up_pin,
	output logic      btn_down_pin,
	output logic      btn_p_pin,
	output logic      btn_e_pin,
	output logic      sync_short_pin,
	output logic      tick_1s_pin
);
	initial begin
		{btn_up_pin, btn_down_pin, btn_p_pin, btn_e_pin} = 4'h0;
		{sync_short_pin, tick_1s_pin} = 2'h0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// P lands first, E later while P held, so the pair has one late edge
	task automatic press(input logic p, input logic e, input logic u, input logic d);
		@(posedge sys_clk);
		btn_p_pin <= p;
		btn_up_pin <= u;
		btn_down_pin <= d;
		hold(2);
		btn_e_pin <= e;
		hold(6);
		{btn_p_pin, btn_e_pin, btn_up_pin, btn_down_pin} <= 4'h0;
		hold(6);
	endtask
	task automatic tick();
		@(posedge sys_clk);
		tick_1s_pin <= 1'b1;
		hold(6);
		tick_1s_pin <= 1'b0;
		hold(6);
	endtask
	task automatic sync(input logic v);
		@(posedge sys_clk);
		sync_short_pin <= v;
		hold(6);
	endtask
endmodule // tdc_panel_model

/* File: sim/tb_top.sv */
// Self-checking bench for the time-of-day clock
`timescale 1ns/1ns
module tb_top;
	import tdc_pkg::*;
	typedef struct {logic [31:0] tm; logic oe_n; logic c1; logic c2; logic [4:0] hr;} tdc_row_t;
	logic         sys_clk = 1'b0;
	logic         rst_n, supply_ok_pin, nvm_ready_pin;
	logic         btn_up_pin, btn_down_pin, btn_p_pin, btn_e_pin, sync_short_pin, tick_1s_pin;
	logic         status_oc_out, status_oc_oe_n, control_output_one, control_output_two;
	logic         nvm_load, nvm_store;
	logic [31:0]  bus_rdata, r, r0;
	tdc_bus_req_t bus_req;
	tdc_disp_t    disp;
	tdc_row_t     rows [3];
	int           n_errors = 0;
	int           n_compared = 0;
	int           cyc = 0;
	always #4 sys_clk = ~sys_clk;
	tdc_clock #(.PWR_LOSS_CYC_P(20), .LAMP_CYC_P(10), .MSG_CYC_P(10)) u_tdc_clock (.*);
	tdc_panel_model u_tdc_panel_model (.*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 r = bus_rdata;
	endtask
	task automatic st(input tdc_state_t s);
		rd(REG_STATUS);
		chk("state", {25'h0, r[10:4]}, {25'h0, s});
	endtask
	function automatic logic [31:0] t(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		return {15'h0, h, m, s};
	endfunction
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		supply_ok_pin = 1'b1;
		nvm_ready_pin = 1'b0;
		rows = '{'{t(23, 59, 59), 0, 0, 0, 23}, '{t(0, 0, 0), 1, 0, 1, 0}, '{t(0, 0, 1), 1, 0, 0, 0}};
		repeat (6) @(posedge sys_clk);
		chk("oe_n in reset", {31'h0, status_oc_oe_n}, 32'h1);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk("all_seg", {31'h0, disp.all_seg}, 32'h1);
		repeat (15) @(posedge sys_clk);
		#1 chk("nvm_load", {31'h0, nvm_load}, 32'h1);
		@(posedge sys_clk);
		nvm_ready_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		st(TDC_ST_RUN);
		chk("flash", {31'h0, disp.flash}, 32'h1);
		chk("12h am", {25'h0, disp.hours, disp.am_mark, disp.pm_mark},
			{25'h0, 5'h0c, 2'h2});
		rd(REG_TIME);
		r0 = r;
		u_tdc_panel_model.tick();
		rd(REG_TIME);
		chk("halted", r, r0);
		$display("test init done");
		u_tdc_panel_model.press(1, 1, 0, 0);
		st(TDC_ST_MENU);
		wr(REG_CTRL, 32'h5);
		wr(REG_SET, t(23, 59, 58));
		wr(REG_SCHED, 32'h1);
		wr(REG_SCHED + {3'h0, SF_ON1}, t(23, 59, 59));
		wr(REG_SCHED + {3'h0, SF_OFF1}, t(0, 0, 0));
		for (int k = 1; k < 3; k++) begin
			wr(REG_SCHED + SCHED_STRIDE * 8'(k), 32'(k));
			wr(REG_SCHED + SCHED_STRIDE * 8'(k) + {3'h0, SF_ON1}, t(6, 0, 0));
			wr(REG_SCHED + SCHED_STRIDE * 8'(k) + {3'h0, SF_OFF1}, t(7, 0, 0));
			wr(REG_SCHED + SCHED_STRIDE * 8'(k) + {3'h0, SF_ON2}, t(0, 0, 0));
			wr(REG_SCHED + SCHED_STRIDE * 8'(k) + {3'h0, SF_OFF2}, t(0, 0, 1));
		end
		wr(REG_CODE, 32'h1);
		u_tdc_panel_model.press(0, 1, 0, 0);
		for (int i = 0; i < 40 && nvm_store !== 1'b1; i++) @(posedge sys_clk);
		#1 chk("store", {29'h0, nvm_store, disp.msg}, {29'h1, TDC_MSG_SAVE});
		repeat (30) @(posedge sys_clk);
		#1 chk("flash", {31'h0, disp.flash}, 32'h0);
		$display("test menu done");
		foreach (rows[i]) begin
			u_tdc_panel_model.tick();
			rd(REG_TIME);
			chk("time", r, rows[i].tm);
			chk("status", {29'h0, status_oc_out, status_oc_oe_n, disp.status_ann},
				{29'h0, 1'b0, rows[i].oe_n, ~rows[i].oe_n});
			chk("control", {30'h0, control_output_one, control_output_two},
				{30'h0, rows[i].c1, rows[i].c2});
			chk("hours", {14'h0, disp.show_sec, disp.hours, disp.minutes, disp.seconds},
				{14'h0, 1'b0, rows[i].hr, rows[i].tm[11:0]});
		end
		for (int i = 1; i < 5; i++) begin
			u_tdc_panel_model.press(0, 0, 1, 0);
			chk("info msg", {29'h0, disp.msg}, 32'(i % 4));
		end
		$display("test schedule done");
		u_tdc_panel_model.sync(1'b1);
		chk("reset_ann", {31'h0, disp.reset_ann}, 32'h1);
		u_tdc_panel_model.tick();
		rd(REG_TIME);
		chk("sync time", r, t(12, 0, 0));
		u_tdc_panel_model.sync(1'b0);
		u_tdc_panel_model.tick();
		rd(REG_TIME);
		chk("resume", r, t(12, 0, 1));
		$display("test sync done");
		u_tdc_panel_model.press(1, 1, 0, 0);
		st(TDC_ST_CODE);
		u_tdc_panel_model.press(1, 0, 0, 0);
		u_tdc_panel_model.press(0, 1, 0, 0);
		st(TDC_ST_RUN);
		u_tdc_panel_model.press(1, 1, 0, 0);
		u_tdc_panel_model.press(1, 0, 0, 0);
		u_tdc_panel_model.press(0, 0, 1, 0);
		u_tdc_panel_model.press(0, 1, 0, 0);
		st(TDC_ST_MENU);
		repeat (11) u_tdc_panel_model.tick();
		st(TDC_ST_RUN);
		$display("test code done");
		wr(REG_SYNC, t(1, 0, 0));
		rd(REG_SYNC);
		chk("sync locked", r, t(12, 0, 0));
		rd(8'hfc);
		chk("unmapped", r, 32'h0);
		@(posedge sys_clk);
		supply_ok_pin <= 1'b0;
		repeat (25) @(posedge sys_clk);
		supply_ok_pin <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 chk("unset", {31'h0, disp.flash}, 32'h1);
		$display("test supply done");
		test_done();
	end
endmodule // tb_top
